// ---- line_iface_pkg.sv ----
// line interface status, mask and clock-select constants and types
// assumes a 32-bit apb slave with one register per aligned word
package line_iface_pkg;

  // ---------------------------------------------------------------
  // register map (printed offsets are indexes; byte address = 4x)
  // ---------------------------------------------------------------
  localparam logic [7:0] RECEIVE_LEVEL_INFO_IDX = 8'h11;
  localparam logic [7:0] LINE_STATUS_IDX = 8'h14;
  localparam logic [7:0] LINE_INTERRUPT_MASK_IDX = 8'h15;
  localparam logic [7:0] LINE_CTRL_TWO_IDX = 8'h31;
  localparam logic [7:0] CLOCK_CTRL_IDX = 8'h33;
  localparam logic [7:0] TX_MODE_IDX = 8'h40;
  localparam logic [7:0] IRQ_STATE_IDX = 8'h41;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int OPEN_BIT = 1;
  localparam int LIMIT_BIT = 2;
  localparam int JITTER_FIFO_LIMIT_EVENT_BIT = 4;
  localparam int PLL_2048_BIT = 3;
  localparam int PLL_12800_BIT = 7;
  localparam int PRESCALE_LO_BIT = 6;
  localparam int PRESCALE_HI_BIT = 7;
  localparam logic [7:0] STATUS_USED_MASK = 8'h16;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int LEVEL_WIDTH = 4;
  localparam int JA_FIFO_DEPTH = 32;
  localparam int JA_LIMIT_MARGIN = 4;

  // transmit mode codes
  typedef enum logic [2:0] {
    TX_T1, TX_E1, TX_CMI, TX_CC64K, TX_6312K
  } tx_mode_type;

  // derived jitter-attenuator clock source
  typedef enum logic [2:0] {
    SRC_DIRECT, SRC_PLL_2048_TO_1544, SRC_PLL_CHAIN, SRC_PLL_12800_TO_2048, SRC_INVALID
  } ja_src_type;

  // decoded master-clock setting carried as one group
  typedef struct packed {
    ja_src_type src;
    logic [1:0] prescale;
    logic valid;
  } clk_sel_type;

  // raw analog detector inputs
  typedef struct packed {
    logic openCircuit;
    logic currentLimit;
    logic [LEVEL_WIDTH-1:0] rxLevel;
  } line_sense_type;

endpackage

// ---- line_iface_status_clock_select.sv ----
// status, interrupt-mask and master-clock prescaler register bank
// assumes apb master on clk; analog detector pins are asynchronous
// Operation
// - E1 clocks direct; 12.8 uses 12800 PLL
// - receive level reported as 4-bit code
// - open-circuit flag; unsupported in 6312k mode
// - current-limit flag sets whether limiter enabled
// - no current-limit flag in CMI/64k/6312k
// - jitter limit event within 4 bits of limit
// - status read clears latched jitter event
// - masked condition interrupts on both edges
// - masked jitter event raises interrupt
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module line_iface_status_clock_select
  import line_iface_pkg::*;
#(
  parameter int FIFO_DEPTH = line_iface_pkg::JA_FIFO_DEPTH,
  parameter int FILL_WIDTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line detectors (asynchronous)
  input wire line_iface_pkg::line_sense_type sense,
  // jitter attenuator fill level (same clock)
  input wire logic [FILL_WIDTH-1:0] jaFill,
  // decoded clock selection and interrupt
  output line_iface_pkg::clk_sel_type clkSel,
  output logic irq
);
  import line_iface_pkg::*;

  // elaboration check: the trip point must fit the fill counter
  if (FIFO_DEPTH <= JA_LIMIT_MARGIN || FIFO_DEPTH >= (1 << FILL_WIDTH)) begin : g_bad_depth
    $error("fifo depth does not fit fill width");
  end

  // ---------------------------------------------------------------
  // detector synchronisers: three stages, change when 2nd and 3rd agree
  // ---------------------------------------------------------------
  // a glitch sampled on only one clock edge never reaches the flags
  logic [5:0] sync1_q;
  logic [5:0] sync1_d;
  logic [5:0] sync2_q;
  logic [5:0] sync2_d;
  logic [5:0] sync3_q;
  logic [5:0] sync3_d;
  logic [5:0] senseStable_q;
  logic [5:0] senseStable_d;

  always_comb begin
    sync1_d = {sense.openCircuit, sense.currentLimit, sense.rxLevel};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    senseStable_d = senseStable_q;
    for (int i = 0; i < 6; i++) begin
      if (sync2_q[i] == sync3_q[i]) senseStable_d[i] = sync3_q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sync3_q <= 6'h00;
      senseStable_q <= 6'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      senseStable_q <= senseStable_d;
    end
  end

  // ---------------------------------------------------------------
  // registers and status flags
  // ---------------------------------------------------------------
  // software-visible control registers
  logic [7:0] lineCtrlTwo_q;
  logic [7:0] lineCtrlTwo_d;
  logic [7:0] clockCtrl_q;
  logic [7:0] clockCtrl_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  tx_mode_type txMode_q;
  tx_mode_type txMode_d;
  // status, pending events and edge history
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  logic prevOpen_q;
  logic prevOpen_d;
  logic prevLimit_q;
  logic prevLimit_d;
  logic jaNear_q;
  logic jaNear_d;
  // registered bus answer and outputs
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic irq_q;
  logic irq_d;
  clk_sel_type clkSel_q;
  clk_sel_type clkSel_d;

  // decode helpers
  logic openNow;
  logic limitNow;
  logic jaNear;
  logic access;
  logic wr;
  logic rd;
  logic [9:0] widx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic hit;

  always_comb begin
    access = psel && penable && !pready_q;
    wr = access && pwrite;
    rd = access && !pwrite;
    widx = paddr[11:2];
    wbyte = pwdata[7:0];
    // open-circuit detect is meaningless when the driver is tristated
    openNow = senseStable_q[5] && (txMode_q != TX_6312K);
    limitNow = senseStable_q[4] && (txMode_q == TX_T1 || txMode_q == TX_E1);
    jaNear = ({{(32-FILL_WIDTH){1'b0}}, jaFill} >= (FIFO_DEPTH - JA_LIMIT_MARGIN));
    // the access is taken once, on its first access-phase edge
  end

  // ---------------------------------------------------------------
  // register file: read mux and write decode
  // ---------------------------------------------------------------
  always_comb begin

    lineCtrlTwo_d = lineCtrlTwo_q;
    clockCtrl_d = clockCtrl_q;
    mask_d = mask_q;
    txMode_d = txMode_q;
    hit = 1'b1;
    rbyte = 8'h00;
    case (widx)
      {2'b00, RECEIVE_LEVEL_INFO_IDX}: rbyte = {4'h0, senseStable_q[3:0]};
      {2'b00, LINE_STATUS_IDX}: rbyte = status_q;
      {2'b00, LINE_INTERRUPT_MASK_IDX}: begin
        rbyte = mask_q;
        if (wr) mask_d = wbyte & STATUS_USED_MASK;
      end
      {2'b00, LINE_CTRL_TWO_IDX}: begin
        rbyte = lineCtrlTwo_q;
        if (wr) lineCtrlTwo_d = wbyte;
      end
      {2'b00, CLOCK_CTRL_IDX}: begin
        rbyte = clockCtrl_q;
        if (wr) clockCtrl_d = wbyte;
      end
      {2'b00, TX_MODE_IDX}: begin
        rbyte = {5'h00, txMode_q};
        if (wr) txMode_d = tx_mode_type'(wbyte[2:0]);
      end
      {2'b00, IRQ_STATE_IDX}: rbyte = pend_q;
      default: hit = 1'b0;
    endcase

  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_comb begin
    // bits 0, 3 and 5 to 7 always read back as zero
    // live conditions plus latched event; event set beats read clear
    status_d = {3'b000, status_q[JITTER_FIFO_LIMIT_EVENT_BIT], 1'b0, limitNow, openNow, 1'b0};
    if (rd && widx == {2'b00, LINE_STATUS_IDX}) status_d[JITTER_FIFO_LIMIT_EVENT_BIT] = 1'b0;
    if (jaNear && !jaNear_q) status_d[JITTER_FIFO_LIMIT_EVENT_BIT] = 1'b1;
    jaNear_d = jaNear;

  end

  // ---------------------------------------------------------------
  // interrupt pending and request
  // ---------------------------------------------------------------
  always_comb begin
    // a masked event still pends, so unmasking later raises irq at once
    // edge events pend until the status register is read
    pend_d = pend_q;
    if (rd && widx == {2'b00, LINE_STATUS_IDX}) pend_d = 8'h00;
    if (openNow != prevOpen_q) pend_d[OPEN_BIT] = 1'b1;
    if (limitNow != prevLimit_q) pend_d[LIMIT_BIT] = 1'b1;
    if (jaNear && !jaNear_q) pend_d[JITTER_FIFO_LIMIT_EVENT_BIT] = 1'b1;
    prevOpen_d = openNow;
    prevLimit_d = limitNow;
    irq_d = |(pend_d & mask_d);

  end

  // ---------------------------------------------------------------
  // bus answer, one cycle after the access is taken
  // ---------------------------------------------------------------
  always_comb begin
    pready_d = access;
    pslverr_d = access && !hit;
    prdata_d = (rd && hit) ? {24'h000000, rbyte} : 32'h00000000;

  end

  // ---------------------------------------------------------------
  // master clock decode
  // ---------------------------------------------------------------
  always_comb begin
    // combinations outside the tables report no usable source
    // master clock decode: T1 when transmit mode says so, else E1
    clkSel_d.prescale = {clockCtrl_q[PRESCALE_HI_BIT], clockCtrl_q[PRESCALE_LO_BIT]};
    clkSel_d.valid = 1'b1;
    case ({lineCtrlTwo_q[PLL_12800_BIT], lineCtrlTwo_q[PLL_2048_BIT]})
      2'b00: clkSel_d.src = SRC_DIRECT;
      2'b01: clkSel_d.src = SRC_PLL_2048_TO_1544;
      2'b11: clkSel_d.src = SRC_PLL_CHAIN;
      2'b10: clkSel_d.src = SRC_PLL_12800_TO_2048;
      default: clkSel_d.src = SRC_INVALID;
    endcase
    if (txMode_q == TX_T1) begin
      if (clkSel_d.src == SRC_PLL_12800_TO_2048) clkSel_d.valid = 1'b0;
      if (clkSel_d.src == SRC_PLL_CHAIN && clkSel_d.prescale != 2'b00)
        clkSel_d.valid = 1'b0;
    end else begin
      if (clkSel_d.src == SRC_PLL_2048_TO_1544 || clkSel_d.src == SRC_PLL_CHAIN)
        clkSel_d.valid = 1'b0;
      if (clkSel_d.src == SRC_PLL_12800_TO_2048 && clkSel_d.prescale != 2'b00)
        clkSel_d.valid = 1'b0;
    end
    if (!clkSel_d.valid) clkSel_d.src = SRC_INVALID;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lineCtrlTwo_q <= REG_RESET;
      clockCtrl_q <= REG_RESET;
      mask_q <= REG_RESET;
      txMode_q <= TX_T1;
      status_q <= REG_RESET;
      pend_q <= REG_RESET;
      prevOpen_q <= 1'b0;
      prevLimit_q <= 1'b0;
      jaNear_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      clkSel_q <= '{src: SRC_DIRECT, prescale: 2'b00, valid: 1'b1};
    end else begin
      lineCtrlTwo_q <= lineCtrlTwo_d;
      clockCtrl_q <= clockCtrl_d;
      mask_q <= mask_d;
      txMode_q <= txMode_d;
      status_q <= status_d;
      pend_q <= pend_d;
      prevOpen_q <= prevOpen_d;
      prevLimit_q <= prevLimit_d;
      jaNear_q <= jaNear_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
      clkSel_q <= clkSel_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // straight from flops, so no comb path reaches a pin
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign clkSel = clkSel_q;

endmodule // line_iface_status_clock_select

// ---- line_iface_chk.sv ----
// checker: bus timing and read-data shape of the line bank
// assumes a bind into the bank; watches its ports only
`timescale 1ns/1ps
module line_iface_chk
  import line_iface_pkg::*;
(
  // clock, reset and bus
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // decoded clock selection
  input wire line_iface_pkg::clk_sel_type clkSel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read completions, by word index
  wire rdEnd = pready && !pwrite;
  wire [9:0] idx = paddr[11:2];
  ready_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error answer carries data");
  level_upper_a: assert property (rdEnd && idx == 10'h11 |-> prdata[31:4] == 28'h0)
    else $error("level upper bits set");
  status_bits_a: assert property (rdEnd && idx == 10'h14 |-> (prdata & 32'hffffffe9) == 32'h0)
    else $error("status unused bits set");
  mask_bits_a: assert property (rdEnd && idx == 10'h15 |-> !(prdata & 32'hffffffe9))
    else $error("mask unused bits set");
  sel_valid_a: assert property (clkSel.valid == (clkSel.src != SRC_INVALID))
    else $error("clock select valid mismatch");
endmodule // line_iface_chk

bind line_iface_status_clock_select line_iface_chk u_chk (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .clkSel(clkSel));

// ---- line_iface_status_clock_select_tb_top.sv ----
// testbench: apb register sequences with expected values for the line bank
// assumes the bank's package; one 25 MHz clock
`timescale 1ns/1ps
module line_iface_status_clock_select_tb_top;
  import line_iface_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, irq, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] jaFill = 6'h0;
  line_sense_type sense = '0;
  clk_sel_type clkSel;
  int n_fail = 0, total_checks = 0;
  // mode, pll selects, prescale, expected src/prescale/valid
  logic [29:0] tab [7] = '{{8'h0, 8'h0, 8'hc0, SRC_DIRECT, 3'h7},
    {8'h0, 8'h08, 8'h40, SRC_PLL_2048_TO_1544, 3'h3}, {8'h0, 8'h88, 8'h0, SRC_PLL_CHAIN, 3'h1},
    {8'h0, 8'h88, 8'h80, SRC_INVALID, 3'h0}, {8'h1, 8'h0, 8'h80, SRC_DIRECT, 3'h5},
    {8'h1, 8'h80, 8'h0, SRC_PLL_12800_TO_2048, 3'h1}, {8'h1, 8'h08, 8'h0, SRC_INVALID, 3'h0}};

  line_iface_status_clock_select u_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense), .jaFill(jaFill), .clkSel(clkSel),
    .irq(irq));

  // free-running 40 ns clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // one apb access; idle cycle first so strobes never double-assign
  task automatic xfer(logic w, logic [7:0] idx, logic [7:0] d);
    int k = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 20) begin
      n_fail++;
      complete_run;
    end
  endtask

  task automatic rdc(string nm, logic [7:0] idx, logic [31:0] e);
    xfer(1'h0, idx, 8'h0);
    chk(nm, e, rd);
  endtask

  // detector inputs pass a synchroniser, so settle a few edges
  task automatic settle(int n);
    repeat (n) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    settle(20);
    rst_b <= 1'h1;
    rdc("status", LINE_STATUS_IDX, 32'h0);
    rdc("mask", LINE_INTERRUPT_MASK_IDX, 32'h0);
    for (int i = 0; i < 16; i++) begin
      sense.rxLevel <= i[3:0];
      settle(6);
      rdc("level", RECEIVE_LEVEL_INFO_IDX, i);
    end
    xfer(1'h1, RECEIVE_LEVEL_INFO_IDX, 8'h0);
    rdc("level ro", RECEIVE_LEVEL_INFO_IDX, 32'hf);
    xfer(1'h1, LINE_INTERRUPT_MASK_IDX, 8'h16);
    rdc("mask", LINE_INTERRUPT_MASK_IDX, 32'h16);
    rdc("unmapped", 8'hff, 32'h0);
    chk("slverr", 32'h1, err);
    for (int i = 0; i < 7; i++) begin
      xfer(1'h1, TX_MODE_IDX, tab[i][29:22]);
      xfer(1'h1, LINE_CTRL_TWO_IDX, tab[i][21:14]);
      xfer(1'h1, CLOCK_CTRL_IDX, tab[i][13:6]);
      settle(2);
      chk("clksel", {tab[i][5:3], tab[i][0]}, {clkSel.src, clkSel.valid});
      if (tab[i][0]) chk("prescale", tab[i][2:1], clkSel.prescale);
    end
    // open-circuit edges, unmasked then masked, then 6312k mode
    xfer(1'h1, TX_MODE_IDX, 8'h0);
    xfer(1'h1, LINE_INTERRUPT_MASK_IDX, 8'h02);
    rdc("status", LINE_STATUS_IDX, 32'h0);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) xfer(1'h1, LINE_INTERRUPT_MASK_IDX, 8'h0);
      sense.openCircuit <= !i[0];
      settle(6);
      chk("irq edge", i < 2, irq);
      rdc("open", LINE_STATUS_IDX, {!i[0], 1'h0});
      settle(2);
      chk("irq clear", 32'h0, irq);
    end
    xfer(1'h1, TX_MODE_IDX, 8'h4);
    sense.openCircuit <= 1'h1;
    settle(6);
    rdc("open 6312k", LINE_STATUS_IDX, 32'h0);
    sense.openCircuit <= 1'h0;
    sense.currentLimit <= 1'h1;
    for (int m = 0; m < 5; m++) begin
      xfer(1'h1, TX_MODE_IDX, m[7:0]);
      settle(6);
      rdc("limit", LINE_STATUS_IDX, m < 2 ? 32'h4 : 32'h0);
    end
    // jitter fill just below and at the trip point
    xfer(1'h1, LINE_INTERRUPT_MASK_IDX, 8'h10);
    jaFill <= 6'(JA_FIFO_DEPTH - JA_LIMIT_MARGIN - 1);
    settle(4);
    rdc("jitter below", LINE_STATUS_IDX, 32'h0);
    jaFill <= 6'(JA_FIFO_DEPTH - JA_LIMIT_MARGIN);
    settle(4);
    chk("irq jitter", 32'h1, irq);
    rdc("pending", IRQ_STATE_IDX, 32'h10);
    rdc("jitter", LINE_STATUS_IDX, 32'h10);
    rdc("jitter read", LINE_STATUS_IDX, 32'h0);
    settle(2);
    chk("irq jitter", 32'h0, irq);
    complete_run;
  end
endmodule // line_iface_status_clock_select_tb_top
